/* hw/ett_core.v */
// Event time-tagger core: capture, time scale, stream and control.
// Overview of operation
// - Coarse counter advances in 10 ns units and forms the event time.
// - Interpolator phase code is captured with each event.
// - Both event inputs are ORed into one capture path.
// - After a capture further edges are ignored for two 25 ns clock cycles (50 ns).
// - Coarse and interpolator codes form one tag sent to the host.
// - Each tag carries an input marker; host resolves times to 1 ps.
// - Time scale wraps after 7 days; host then resynchronises.
// - Software selects the active edge of each event input.
// - Software programs the comparator threshold of each input.
// - The gate pin qualifies input B only, never input A.
// - An undriven gate pin leaves input B enabled.
// - A rising edge on the start pin starts the measurement.
// - A periodic output pulse has a software-set period.
// - Reference presence and 5 or 10 MHz are detected automatically.
// - Seconds pulse presence is detected and blinks an indicator.
// - Reference and seconds pulse align the time scale to UTC.
// - Calibration indicator blinks while calibration runs.
// - Tags stream without gaps; host must keep up.
// - Temperature readings are inserted into the stream.
// - Internal clock is locked to the external reference.
// - Gate low enables input B, gate high inhibits it.
// - Pulse period 40 ns to 1 ms in 10 ns steps.
// - Edge choice is positive, negative or both.
`timescale 1ns/1ps
`include "ett_defines.vh"
module ett_core
#(
  parameter PPS_TIMEOUT_CYC = 26'd60000000,
  parameter BLINK_CYC       = 26'd4000000,
  parameter TEMP_CYC        = 26'd40000000
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Pins
  input  wire        event_a_pin,
  input  wire        event_b_pin,
  input  wire        gate_pin,
  input  wire        external_start_pin,
  input  wire        ref_pin,
  input  wire        seconds_pulse_pin,
  output reg         aux_out,
  // Front end
  input  wire [11:0] interp_code,
  input  wire [11:0] temp_code,
  output reg  [11:0] thr_a,
  output reg  [11:0] thr_b,
  output reg         pll_ref_ext,
  output reg         pll_ref_10m,
  // Indicators
  output reg         led_ref,
  output reg         led_pps,
  output reg         led_cal,
  // Tag stream
  input  wire        tag_ready,
  output reg  [63:0] tag_data,
  output reg         tag_valid
);

  localparam integer DEAD_INT =
    (`ETT_DEAD_NS * 1000 + `ETT_CLK_PS - 1) / `ETT_CLK_PS;
  localparam integer REF_WIN_INT = `ETT_REF_WIN_NS * 1000 / `ETT_CLK_PS;
  localparam integer CLK_NS_INT  = `ETT_CLK_PS / 1000;
  localparam [1:0]  DEAD_CYC    = DEAD_INT[1:0];
  localparam [5:0]  REF_WIN_CYC = REF_WIN_INT[5:0];
  localparam [23:0] CLK_NS      = CLK_NS_INT[23:0];

  function [16:0] clamp_period;
    input [16:0] p;
    begin
      if (p < `ETT_AUX_MIN)
        clamp_period = `ETT_AUX_MIN;
      else if (p > `ETT_AUX_MAX)
        clamp_period = `ETT_AUX_MAX;
      else
        clamp_period = p;
    end
  endfunction

  function edge_hit;
    input [1:0] mode;
    input       r;
    input       f;
    begin
      edge_hit = (mode[0] & r) | (mode[1] & f);
    end
  endfunction

  wire        lvl_a;
  wire        rise_a;
  wire        fall_a;
  wire        lvl_b;
  wire        rise_b;
  wire        fall_b;
  wire        gate_lvl;
  wire        start_rise;
  wire        ref_rise;
  wire        pps_rise;

  reg  [7:0]  ctrl;
  reg  [16:0] aux_per;
  reg         running;
  reg         synced;
  reg         wrap_seen;
  reg         overrun;
  reg  [45:0] coarse;
  reg         half;
  reg  [1:0]  dead;
  reg  [23:0] aux_acc;
  reg  [5:0]  ref_win;
  reg  [3:0]  ref_cnt;
  reg  [25:0] pps_age;
  reg  [25:0] pps_blink;
  reg  [25:0] cal_cnt;
  reg  [25:0] temp_cnt;
  reg         temp_pend;

  reg  [45:0] next_coarse;
  reg         next_wrap;
  wire        hit_a;
  wire        hit_b;
  wire        hit;
  wire [23:0] per_ns;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  ett_pin_sync u_sync_a (.clk(clk), .rstn(rstn), .pin(event_a_pin),
    .level(lvl_a), .rise(rise_a), .fall(fall_a));
  ett_pin_sync u_sync_b (.clk(clk), .rstn(rstn), .pin(event_b_pin),
    .level(lvl_b), .rise(rise_b), .fall(fall_b));
  ett_pin_sync u_sync_g (.clk(clk), .rstn(rstn), .pin(gate_pin),
    .level(gate_lvl), .rise(), .fall());
  ett_pin_sync u_sync_t (.clk(clk), .rstn(rstn), .pin(external_start_pin),
    .level(), .rise(start_rise), .fall());
  ett_pin_sync u_sync_r (.clk(clk), .rstn(rstn), .pin(ref_pin),
    .level(), .rise(ref_rise), .fall());
  ett_pin_sync u_sync_p (.clk(clk), .rstn(rstn), .pin(seconds_pulse_pin),
    .level(), .rise(pps_rise), .fall());

  // ----------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------
  // Input B is qualified by the gate level; A is never gated.
  assign hit_a = edge_hit(ctrl[`ETT_CTRL_EDGE_A], rise_a, fall_a);
  assign hit_b = edge_hit(ctrl[`ETT_CTRL_EDGE_B], rise_b, fall_b)
                 & ~gate_lvl;
  assign hit   = running && (dead == 2'h0) && (hit_a | hit_b);

  // ----------------------------------------------------------------------
  // Coarse time scale
  // ----------------------------------------------------------------------
  // A 25 ns clock adds 2 and 3 coarse steps alternately.
  always @*
  begin
    next_coarse = coarse + (half ? 46'h3 : 46'h2);
    next_wrap   = 1'b0;
    if (next_coarse >= `ETT_COARSE_WRAP)
    begin
      next_coarse = next_coarse - `ETT_COARSE_WRAP;
      next_wrap   = 1'b1;
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coarse <= 46'h0;
      half   <= 1'b0;
      synced <= 1'b0;
    end
    else if (pps_rise && ctrl[`ETT_CTRL_SYNC_ARM])
    begin
      coarse <= 46'h0;
      half   <= 1'b0;
      synced <= 1'b1;
    end
    else
    begin
      coarse <= next_coarse;
      half   <= ~half;
      if (next_wrap)
        synced <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Dead time and run control
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dead    <= 2'h0;
      running <= 1'b0;
    end
    else
    begin
      if (hit)
        dead <= DEAD_CYC;
      else if (dead != 2'h0)
        dead <= dead - 2'h1;
      if (!ctrl[`ETT_CTRL_RUN])
        running <= 1'b0;
      else if (!ctrl[`ETT_CTRL_TRIG_ARM])
        running <= 1'b1;
      else if (start_rise)
        running <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Tag stream
  // ----------------------------------------------------------------------
  // Events win the slot; a wrap record in the same cycle is dropped, temperature records follow.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tag_data  <= 64'h0;
      tag_valid <= 1'b0;
      temp_cnt  <= 26'h0;
      temp_pend <= 1'b0;
    end
    else
    begin
      tag_valid <= 1'b0;
      if (temp_cnt == TEMP_CYC - 26'h1)
        temp_cnt <= 26'h0;
      else
        temp_cnt <= temp_cnt + 26'h1;
      if (temp_cnt == TEMP_CYC - 26'h1)
        temp_pend <= 1'b1;
      if (hit)
      begin
        tag_valid <= 1'b1;
        tag_data  <= {(hit_a ? `ETT_TAG_A : `ETT_TAG_B),
                      hit_a & hit_b, 3'h0, coarse, interp_code};
      end
      else if (next_wrap)
      begin
        tag_valid <= 1'b1;
        tag_data  <= {`ETT_TAG_WRAP, 4'h0, 46'h0, 12'h0};
      end
      else if (temp_pend)
      begin
        tag_valid <= 1'b1;
        tag_data  <= {`ETT_TAG_TEMP, 4'h0, coarse, temp_code};
        temp_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Periodic output
  // ----------------------------------------------------------------------
  assign per_ns = {7'h0, aux_per} * 24'd10;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aux_acc <= 24'h0;
      aux_out <= 1'b0;
    end
    else if (aux_acc + CLK_NS >= per_ns)
    begin
      aux_acc <= aux_acc + CLK_NS - per_ns;
      aux_out <= 1'b1;
    end
    else
    begin
      aux_acc <= aux_acc + CLK_NS;
      aux_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Reference detection
  // ----------------------------------------------------------------------
  // Edges in a 1 us window: 10 MHz gives about 10, 5 MHz about 5.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_win     <= 6'h0;
      ref_cnt     <= 4'h0;
      pll_ref_ext <= 1'b0;
      pll_ref_10m <= 1'b0;
      led_ref     <= 1'b0;
    end
    else if (ref_win == REF_WIN_CYC - 6'h1)
    begin
      ref_win     <= 6'h0;
      ref_cnt     <= 4'h0;
      pll_ref_ext <= ref_cnt >= 4'h3;
      pll_ref_10m <= ref_cnt >= 4'h8;
      led_ref     <= ref_cnt >= 4'h3;
    end
    else
    begin
      ref_win <= ref_win + 6'h1;
      if (ref_rise && ref_cnt != 4'hF)
        ref_cnt <= ref_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Seconds pulse and calibration indicators
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pps_age   <= PPS_TIMEOUT_CYC;
      pps_blink <= 26'h0;
      led_pps   <= 1'b0;
      cal_cnt   <= 26'h0;
      led_cal   <= 1'b0;
    end
    else
    begin
      if (pps_rise)
      begin
        pps_age   <= 26'h0;
        pps_blink <= BLINK_CYC;
      end
      else
      begin
        if (pps_age != PPS_TIMEOUT_CYC)
          pps_age <= pps_age + 26'h1;
        if (pps_blink != 26'h0)
          pps_blink <= pps_blink - 26'h1;
      end
      led_pps <= (pps_blink != 26'h0) && (pps_age != PPS_TIMEOUT_CYC);
      if (!ctrl[`ETT_CTRL_CAL])
      begin
        cal_cnt <= 26'h0;
        led_cal <= 1'b0;
      end
      else if (cal_cnt == BLINK_CYC - 26'h1)
      begin
        cal_cnt <= 26'h0;
        led_cal <= ~led_cal;
      end
      else
        cal_cnt <= cal_cnt + 26'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl      <= `ETT_CTRL_RESET;
      thr_a     <= `ETT_THR_RESET;
      thr_b     <= `ETT_THR_RESET;
      aux_per   <= `ETT_AUX_RESET;
      wrap_seen <= 1'b0;
      overrun   <= 1'b0;
    end
    else
    begin
      if (wr && addr == `ETT_REG_CTRL)
        ctrl <= wdata[7:0];
      if (wr && addr == `ETT_REG_THR_A)
        thr_a <= wdata[11:0];
      if (wr && addr == `ETT_REG_THR_B)
        thr_b <= wdata[11:0];
      if (wr && addr == `ETT_REG_AUX_PER)
        aux_per <= clamp_period(wdata[16:0]);
      if (next_wrap)
        wrap_seen <= 1'b1;
      else if (wr && addr == `ETT_REG_STATUS && wdata[`ETT_ST_WRAP])
        wrap_seen <= 1'b0;
      if (tag_valid && !tag_ready)
        overrun <= 1'b1;
      else if (wr && addr == `ETT_REG_STATUS && wdata[`ETT_ST_OVERRUN])
        overrun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0;
    else if (!rd)
      rdata <= 32'h0;
    else
    begin
      case (addr)
        `ETT_REG_CTRL:      rdata <= {24'h0, ctrl};
        `ETT_REG_STATUS:    rdata <= {25'h0, overrun, wrap_seen, synced,
                                      pps_age != PPS_TIMEOUT_CYC,
                                      pll_ref_10m, pll_ref_ext, running};
        `ETT_REG_THR_A:     rdata <= {20'h0, thr_a};
        `ETT_REG_THR_B:     rdata <= {20'h0, thr_b};
        `ETT_REG_AUX_PER:   rdata <= {15'h0, aux_per};
        `ETT_REG_TEMP:      rdata <= {20'h0, temp_code};
        `ETT_REG_COARSE_LO: rdata <= coarse[31:0];
        `ETT_REG_COARSE_HI: rdata <= {18'h0, coarse[45:32]};
        default:            rdata <= 32'h0;
      endcase
    end
  end

endmodule

/* hw/ett_defines.vh */
// Register offsets, field positions, reset values and timing constants.
`ifndef ETT_DEFINES_VH
`define ETT_DEFINES_VH

// ----------------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------------
`define ETT_REG_CTRL      4'h0
`define ETT_REG_STATUS    4'h1
`define ETT_REG_THR_A     4'h2
`define ETT_REG_THR_B     4'h3
`define ETT_REG_AUX_PER   4'h4
`define ETT_REG_TEMP      4'h5
`define ETT_REG_COARSE_LO 4'h6
`define ETT_REG_COARSE_HI 4'h7

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define ETT_CTRL_RUN      0
`define ETT_CTRL_TRIG_ARM 1
`define ETT_CTRL_SYNC_ARM 2
`define ETT_CTRL_CAL      3
`define ETT_CTRL_EDGE_A   5:4
`define ETT_CTRL_EDGE_B   7:6
`define ETT_CTRL_RESET    8'h50

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define ETT_ST_RUNNING    0
`define ETT_ST_REF_EXT    1
`define ETT_ST_REF_10M    2
`define ETT_ST_PPS_SEEN   3
`define ETT_ST_SYNCED     4
`define ETT_ST_WRAP       5
`define ETT_ST_OVERRUN    6

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define ETT_THR_RESET     12'h800
`define ETT_AUX_RESET     17'h00064
`define ETT_AUX_MIN       17'h00004
`define ETT_AUX_MAX       17'h186A0
`define ETT_COARSE_WRAP   46'h3701_98E6_8000

// ----------------------------------------------------------------------
// Stream record types
// ----------------------------------------------------------------------
`define ETT_TAG_A         2'h0
`define ETT_TAG_B         2'h1
`define ETT_TAG_TEMP      2'h2
`define ETT_TAG_WRAP      2'h3

// ----------------------------------------------------------------------
// Times
// ----------------------------------------------------------------------
`define ETT_CLK_PS        25000
`define ETT_COARSE_NS     10
`define ETT_DEAD_NS       40
`define ETT_REF_WIN_NS    1000

`endif

/* hw/ett_pin_sync.v */
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
module ett_pin_sync
(
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Pin
  input  wire pin,
  // Filtered level and edges
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg s1;
  reg s2;
  reg s3;

  // ----------------------------------------------------------------------
  // Sampling and filtering
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else
    begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      rise  <= (s2 == s3) && s3 && !level;
      fall  <= (s2 == s3) && !s3 && level;
      if (s2 == s3)
        level <= s3;
    end
  end

endmodule

/* tb/ett_core_chk.sv */
// Concurrent port checks for the event time-tagger core.
`timescale 1ns/1ps
module ett_core_chk
#(
  parameter BLINK_CYC = 26'd4000000
)
(
  // Clock and reset
  input wire        clk,
  input wire        rstn,
  // Register port
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // Pins and front end
  input wire        gate_pin,
  input wire [11:0] interp_code,
  input wire [11:0] thr_a,
  input wire        pll_ref_ext,
  input wire        pll_ref_10m,
  input wire        led_cal,
  // Tag stream
  input wire [63:0] tag_data,
  input wire        tag_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------------
  // Calibration blink watchdog
  // ----------------------------------------------------------------------
  reg        cal_q;
  reg        led_q;
  reg [27:0] hold_cnt;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cal_q    <= 1'b0;
      led_q    <= 1'b0;
      hold_cnt <= 28'h0;
    end
    else
    begin
      if (wr && addr == 4'h0)
        cal_q <= wdata[3];
      led_q <= led_cal;
      if (!cal_q || led_cal != led_q)
        hold_cnt <= 28'h0;
      else
        hold_cnt <= hold_cnt + 28'h1;
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_rdata_idle; !rd |=> rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_unmapped; rd && addr > 4'h7 |=> rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  property p_thr_write;
    wr && addr == 4'h2 |=> thr_a == $past(wdata[11:0]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold output does not follow write");
  property p_dead_time;
    tag_valid && !tag_data[63] |=> !(tag_valid && !tag_data[63]) [*2];
  endproperty
  a_dead_time: assert property (p_dead_time)
    else $error("event record inside dead time");
  property p_interp;
    tag_valid && !tag_data[63] |-> tag_data[11:0] == $past(interp_code);
  endproperty
  a_interp: assert property (p_interp)
    else $error("event record lacks captured phase code");
  property p_marker;
    tag_valid && !tag_data[63] |->
      tag_data[60:58] == 3'h0 && (!tag_data[61] || !tag_data[62]);
  endproperty
  a_marker: assert property (p_marker)
    else $error("event record marker field malformed");
  property p_gate;
    tag_valid && tag_data[63:62] == 2'h1 |-> $past(gate_pin, 3) == 1'b0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("input B record while gate inhibits");
  property p_wrap_rec;
    tag_valid && tag_data[63:62] == 2'h3 |-> tag_data[57:0] == 58'h0;
  endproperty
  a_wrap_rec: assert property (p_wrap_rec)
    else $error("wrap record carries nonzero payload");
  property p_ref; pll_ref_10m |-> pll_ref_ext; endproperty
  a_ref: assert property (p_ref)
    else $error("10 MHz flagged without reference present");
  property p_cal; hold_cnt <= BLINK_CYC + 4; endproperty
  a_cal: assert property (p_cal)
    else $error("calibration indicator stopped blinking");
endmodule

bind ett_core ett_core_chk #(.BLINK_CYC(BLINK_CYC)) i_chk (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .gate_pin(gate_pin), .interp_code(interp_code),
  .thr_a(thr_a), .pll_ref_ext(pll_ref_ext), .pll_ref_10m(pll_ref_10m),
  .led_cal(led_cal), .tag_data(tag_data), .tag_valid(tag_valid));

/* tb/ett_host_model.sv */
// Host-side stream consumer that keeps counts and the latest records.
`timescale 1ns/1ps
module ett_host_model
(
  // Clock and reset
  input  wire         clk,
  input  wire         rstn,
  // Tag stream
  input  wire  [63:0] tag_data,
  input  wire         tag_valid,
  output logic        tag_ready,
  // Bench control and observation
  input  wire         stall,
  output logic [31:0] n_evt,
  output logic [31:0] n_temp,
  output logic [63:0] last_evt,
  output logic [63:0] last_temp
);
  assign tag_ready = ~stall;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      n_evt     <= 32'h0;
      n_temp    <= 32'h0;
      last_evt  <= 64'h0;
      last_temp <= 64'h0;
    end
    else if (tag_valid && !tag_data[63])
    begin
      n_evt    <= n_evt + 32'h1;
      last_evt <= tag_data;
    end
    else if (tag_valid && tag_data[63:62] == 2'h2)
    begin
      n_temp    <= n_temp + 32'h1;
      last_temp <= tag_data;
    end
  end
endmodule

/* tb/ett_core_tb_top.sv */
// Self-checking bench for the event time-tagger core.
`timescale 1ns/1ps
module ett_core_tb_top;
  logic        clk, rstn, wr, rd, stall, ref_on;
  logic        event_a_pin, event_b_pin, gate_pin;
  logic        external_start_pin, ref_pin, led_q, seconds_pulse_pin;
  logic [3:0]  addr;
  logic [31:0] wdata, got;
  logic [11:0] interp_code, temp_code;
  wire  [31:0] rdata, n_evt, n_temp;
  wire  [11:0] thr_a, thr_b;
  wire  [63:0] tag_data, last_evt, last_temp;
  wire         aux_out, pll_ref_ext, pll_ref_10m, led_ref, led_pps;
  wire         led_cal, tag_valid, tag_ready;
  int          mismatches, samples_checked, i, k, ne;
  int          ref_half = 4;
  ett_core #(.PPS_TIMEOUT_CYC(26'd200), .BLINK_CYC(26'd8),
    .TEMP_CYC(26'd50)) i_dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .event_a_pin(event_a_pin), .event_b_pin(event_b_pin),
    .gate_pin(gate_pin), .external_start_pin(external_start_pin),
    .ref_pin(ref_pin), .seconds_pulse_pin(seconds_pulse_pin),
    .aux_out(aux_out),
    .interp_code(interp_code), .temp_code(temp_code), .thr_a(thr_a),
    .thr_b(thr_b), .pll_ref_ext(pll_ref_ext), .pll_ref_10m(pll_ref_10m),
    .led_ref(led_ref), .led_pps(led_pps), .led_cal(led_cal),
    .tag_ready(tag_ready), .tag_data(tag_data), .tag_valid(tag_valid));
  ett_host_model i_host (.clk(clk), .rstn(rstn), .tag_data(tag_data),
    .tag_valid(tag_valid), .tag_ready(tag_ready), .stall(stall),
    .n_evt(n_evt), .n_temp(n_temp), .last_evt(last_evt),
    .last_temp(last_temp));
  // ----------------------------------------------------------------------
  // Clock, reference source and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always
  begin
    repeat (ref_half) @(posedge clk);
    if (ref_on)
      ref_pin <= ~ref_pin;
  end
  initial
  begin
    #(25 * 6000);
    mismatches++;
    results;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(got & m, e);
  endtask
  task automatic pins(input logic [1:0] ab, input logic lvl);
    @(posedge clk);
    if (ab[0]) event_a_pin <= lvl;
    if (ab[1]) event_b_pin <= lvl;
    repeat (10) @(posedge clk);
  endtask
  task automatic results;
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {rstn, wr, rd, stall, ref_on, event_a_pin, event_b_pin} = 7'h0;
    {gate_pin, external_start_pin, ref_pin, seconds_pulse_pin} = 4'h0;
    addr = 4'h0; wdata = 32'h0; interp_code = 12'hABC;
    temp_code = 12'h5A5; mismatches = 0; samples_checked = 0; ne = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(4'h0, 32'h50, 32'hFF);
    rd_chk(4'h2, 32'h800, 32'hFFF);
    rd_chk(4'h4, 32'h64, 32'h1FFFF);
    rd_chk(4'h1, 32'h0, 32'h7F);
    wr_reg(4'hF, 32'hFFFF);
    rd_chk(4'hF, 32'h0, 32'hFFFFFFFF);
    wr_reg(4'h2, 32'h123);
    #1 chk({thr_a, thr_b}, 24'h123800);
    wr_reg(4'h4, 32'h1FFFF);
    rd_chk(4'h4, 32'h186A0, 32'h1FFFF);
    wr_reg(4'h4, 32'h1);
    rd_chk(4'h4, 32'h4, 32'h1FFFF);
    wr_reg(4'h4, 32'hA);
    repeat (8) @(posedge clk);
    k = 0;
    repeat (80)
    begin
      @(posedge clk);
      #1 k += aux_out;
    end
    chk(k >= 19 && k <= 21, 1'b1);
    rd_chk(4'h6, 32'h0, 32'h0);
    got = rdata;
    k = got;
    rd_chk(4'h6, 32'h0, 32'h0);
    chk(got - k, 32'h5);
    rd_chk(4'h7, 32'h0, 32'hFFFFFFFF);
    wr_reg(4'h0, 32'h53);
    rd_chk(4'h1, 32'h0, 32'h1);
    pins(2'h1, 1'b1);
    pins(2'h1, 1'b0);
    chk(n_evt, 0);
    @(posedge clk);
    external_start_pin <= 1'b1;
    repeat (10) @(posedge clk);
    external_start_pin <= 1'b0;
    rd_chk(4'h1, 32'h1, 32'h1);
    for (i = 1; i < 4; i++)
    begin
      wr_reg(4'h0, 32'h43 | (i << 4));
      pins(2'h1, 1'b1);
      pins(2'h1, 1'b0);
      ne += (i & 1) + (i >> 1);
      chk(n_evt, ne);
      chk({last_evt[63:58], last_evt[11:0]}, 18'hABC);
    end
    wr_reg(4'h0, 32'h53);
    gate_pin <= 1'b1;
    pins(2'h2, 1'b1);
    pins(2'h2, 1'b0);
    chk(n_evt, ne);
    pins(2'h1, 1'b1);
    pins(2'h1, 1'b0);
    chk(n_evt, ne + 1);
    gate_pin <= 1'b0;
    pins(2'h2, 1'b1);
    chk({n_evt, last_evt[63:61]}, {ne + 2, 3'b010});
    pins(2'h3, 1'b0);
    pins(2'h3, 1'b1);
    chk({n_evt, last_evt[63:61]}, {ne + 3, 3'b001});
    pins(2'h3, 1'b0);
    stall <= 1'b1;
    pins(2'h1, 1'b1);
    stall <= 1'b0;
    rd_chk(4'h1, 32'h40, 32'h40);
    wr_reg(4'h1, 32'h40);
    rd_chk(4'h1, 32'h0, 32'h40);
    chk(n_evt, ne + 4);
    pins(2'h1, 1'b0);
    repeat (60) @(posedge clk);
    chk(n_temp != 0, 1'b1);
    chk({last_temp[63:62], last_temp[11:0]}, 14'h25A5);
    rd_chk(4'h5, 32'h5A5, 32'hFFF);
    wr_reg(4'h0, 32'h57);
    seconds_pulse_pin <= 1'b1;
    repeat (7) @(posedge clk);
    seconds_pulse_pin <= 1'b0;
    #1 chk(led_pps, 1'b1);
    rd_chk(4'h1, 32'h18, 32'h18);
    rd_chk(4'h6, 32'h0, 32'hFFFFFF00);
    repeat (20) @(posedge clk);
    #1 chk(led_pps, 1'b0);
    ref_on <= 1'b1;
    repeat (200) @(posedge clk);
    chk({pll_ref_ext, pll_ref_10m, led_ref}, 3'b101);
    rd_chk(4'h1, 32'h2, 32'h6);
    ref_half = 2;
    repeat (200) @(posedge clk);
    chk({pll_ref_ext, pll_ref_10m, led_ref}, 3'b111);
    rd_chk(4'h1, 32'h6, 32'h6);
    wr_reg(4'h0, 32'h5B);
    k = 0;
    led_q = led_cal;
    repeat (40)
    begin
      @(posedge clk);
      #1 k += (led_cal != led_q);
      led_q = led_cal;
    end
    chk(k > 0, 1'b1);
    results;
  end
endmodule
